// ===== rsc_chk.sv
// Purpose: Port-level checks for the reset source controller
// Assumes: One clock domain; hreadyout serves as bus hready
// Notes:   Delay bounds allow for sync and record latency
`timescale 1ns/1ps
module rsc_chk
    import rsc_pkg::*;
#(
    parameter logic [PIN_CNT_W-1:0] PIN_LOW_CYC = PIN_LOW_CYC_DEF
) (
    // Clock and reset
    input wire logic             ref_clk,
    input wire logic             reset,
    // Bus
    input wire logic             hsel,
    input wire logic [31:0]      haddr,
    input wire logic [1:0]       htrans,
    input wire logic             hwrite,
    input wire logic [31:0]      hwdata,
    input wire logic             hreadyout,
    input wire logic [31:0]      hrdata,
    // Sources and chip side
    input wire logic             external_reset_pin_n,
    input wire logic             supply_good,
    input wire logic             low_voltage,
    input wire logic             flash_erase_req,
    input wire logic             flash_write_req,
    input wire logic [FL_AW-1:0] flash_addr,
    input wire logic             debug_reset_req,
    input wire logic             chip_reset,
    input wire logic [15:0]      boot_address
);
    logic                 hit;
    logic                 dp_cw;
    logic                 dp_cr;
    logic [PIN_CNT_W-1:0] low_cnt;

    assign hit = hsel && htrans[1] && hreadyout && haddr[IDX_MSB:IDX_LSB] == IDX_CAUSE;

    // Raw pin low time; saturates so the check keeps firing while held
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            dp_cw   <= 1'b0;
            dp_cr   <= 1'b0;
            low_cnt <= '0;
        end else begin
            dp_cw <= hit && hwrite;
            dp_cr <= hit && !hwrite;
            if (external_reset_pin_n)
                low_cnt <= '0;
            else if (low_cnt != PIN_LOW_CYC)
                low_cnt <= low_cnt + PIN_CNT_W'(1);
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    boot_vector_a: assert property (boot_address == BOOT_ADDR)
        else $error("boot address not zero");
    supply_hold_a: assert property (!supply_good |-> ##[1:2] chip_reset)
        else $error("chip released with supply low");
    release_cond_a: assert property ($fell(chip_reset) |->
        $past(supply_good) && !$past(low_voltage))
        else $error("release without good supply");
    lv_reset_a: assert property (low_voltage |-> ##[1:3] chip_reset)
        else $error("low voltage did not reset");
    flash_erase_a: assert property (flash_erase_req
        && flash_addr >= FL_SECT_BASE |-> ##[1:3] chip_reset)
        else $error("last sector erase did not reset");
    flash_write_a: assert property (flash_write_req
        && flash_addr == FL_LAST_BYTE |-> ##[1:3] chip_reset)
        else $error("last byte write did not reset");
    debug_reset_a: assert property (debug_reset_req |-> ##[1:3] chip_reset)
        else $error("debug request did not reset");
    soft_reset_a: assert property (dp_cw && hwdata[B_SOFT] |-> ##[1:3] chip_reset)
        else $error("software trigger did not reset");
    pin_reset_a: assert property (low_cnt == PIN_LOW_CYC |-> ##[0:6] chip_reset)
        else $error("long pin low did not reset");
    rsvd_zero_a: assert property (dp_cr |-> hrdata[4] == 1'b0 && hrdata[31:8] == 24'h0)
        else $error("reserved cause bits not zero");

    cover property (dp_cw && hwdata[B_SOFT]);
    cover property (low_cnt == PIN_LOW_CYC);
    cover property ($fell(chip_reset));
endmodule : rsc_chk

bind rsc_reset_source_control rsc_chk #(.PIN_LOW_CYC(PIN_LOW_CYC)) rsc_chk_i (
    .ref_clk(ref_clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hreadyout(hreadyout), .hrdata(hrdata),
    .external_reset_pin_n(external_reset_pin_n), .supply_good(supply_good),
    .low_voltage(low_voltage), .flash_erase_req(flash_erase_req),
    .flash_write_req(flash_write_req), .flash_addr(flash_addr),
    .debug_reset_req(debug_reset_req), .chip_reset(chip_reset), .boot_address(boot_address)
);

// ===== rsc_pkg.sv
// Purpose: Constants and types shared by the reset source controller.
// Assumes: 125 MHz ref_clk, word-aligned AHB-Lite registers.
// Notes:   Register indices times four give byte addresses.
package rsc_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int              CLK_MHZ         = 125;
    localparam int              PIN_LOW_US      = 50;
    localparam int              PIN_CNT_W       = 13;
    // Least time: exact product, no rounding needed
    localparam logic [12:0]     PIN_LOW_CYC_DEF = 13'(PIN_LOW_US * CLK_MHZ);
    localparam int              HOLD_W          = 4;
    localparam logic [3:0]      HOLD_CYC        = 4'hF;
    localparam int              WDT_W           = 16;
    localparam logic [15:0]     WDT_MAX         = 16'hFFFF;

    // ------------------------------------------------------------
    // Flash guard
    // ------------------------------------------------------------
    localparam int              FL_AW           = 14;
    localparam logic [13:0]     FL_SECT_BASE    = 14'h3F80;
    localparam logic [13:0]     FL_LAST_BYTE    = 14'h3FFF;
    localparam logic [15:0]     BOOT_ADDR       = 16'h0000;

    // ------------------------------------------------------------
    // Register map (word indices)
    // ------------------------------------------------------------
    localparam int              IDX_LSB         = 2;
    localparam int              IDX_MSB         = 11;
    localparam logic [9:0]      IDX_CAUSE       = 10'h0C9;
    localparam logic [9:0]      IDX_WCTL        = 10'h0CA;
    localparam logic [9:0]      IDX_ISTS        = 10'h0CB;
    localparam logic [9:0]      IDX_IEN         = 10'h0CC;
    localparam logic [9:0]      IDX_ICLR        = 10'h0CD;

    // Cause register bit positions
    localparam int              B_POW           = 7;
    localparam int              B_EXT           = 6;
    localparam int              B_LVD           = 5;
    localparam int              B_WDT           = 3;
    localparam int              B_FED           = 2;
    localparam int              B_DBG           = 1;
    localparam int              B_SOFT          = 0;
    localparam int              CAUSE_W         = 8;
    localparam logic [7:0]      CAUSE_CLR_MASK  = 8'hF9;
    localparam logic [7:0]      CAUSE_RST       = 8'h80;

    // Watchdog control bits
    localparam int              WCTL_EN         = 0;
    localparam int              WCTL_REFRESH    = 1;

    // AHB-Lite
    localparam int              HTRANS_ACT_BIT  = 1;
    localparam logic            HRESP_OKAY      = 1'b0;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_POWER = 2'b00,
        ST_HOLD  = 2'b01,
        ST_RUN   = 2'b11
    } rsc_state_e;

    typedef struct packed {
        rsc_state_e             st;
        logic                   sync1;
        logic                   sync2;
        logic [PIN_CNT_W-1:0]   pin_cnt;
        logic [HOLD_W-1:0]      hold_cnt;
        logic [CAUSE_W-1:0]     cause;
        logic                   wdt_en;
        logic [WDT_W-1:0]       wdt_cnt;
        logic [CAUSE_W-1:0]     int_sts;
        logic [CAUSE_W-1:0]     int_en;
        logic                   irq;
        logic                   chip_rst;
        logic [15:0]            boot_addr;
        logic                   dp_act;
        logic                   dp_wr;
        logic [9:0]             dp_idx;
        logic                   rdy;
        logic [31:0]            hrdata;
    } rsc_regs_s;

endpackage : rsc_pkg

// ===== rsc_reset_source_control.sv
// Purpose: Chip reset controller with seven reset sources and a
//          software-readable record of the last cause.
// Assumes: All inputs synchronous to ref_clk except the reset pin.
// Notes:   Single-cycle AHB-Lite slave, zero wait states.
//
// Notes on behaviour
// - Seven sources; only last cause flag set
// - Bit 7 write one clears 7:3, 0
// - Low-voltage and watchdog resets never maskable
// - Pin low 50 us resets; boot 0x0000
// - Hold reset until supply reported good
// - Supply low asserts power-on reset, recorded
// - Watchdog refresh restarts counter; overflow resets
// - Flash last-sector erase or last-byte write resets
// - Flash error reset has no disable
// - Bit 0 write one resets; reads one after
// - Cause bit layout; bit 4 reads zero
// - Bit 1 marks debug reset
// - Bits 6:1 read-only to software
//
// Local design decision: the AHB-Lite register port.
`timescale 1ns/1ps

module rsc_reset_source_control
    import rsc_pkg::*;
#(
    parameter logic [PIN_CNT_W-1:0] PIN_LOW_CYC = PIN_LOW_CYC_DEF
) (
    // Clock and reset
    input  wire logic               ref_clk,
    input  wire logic               reset,

    // AHB-Lite slave
    input  wire logic               hsel,
    input  wire logic [31:0]        haddr,
    input  wire logic [1:0]         htrans,
    input  wire logic               hwrite,
    input  wire logic [2:0]         hsize,
    input  wire logic [31:0]        hwdata,
    input  wire logic               hready,
    output logic                    hreadyout,
    output logic [31:0]             hrdata,
    output logic                    hresp,

    // Reset sources
    input  wire logic               external_reset_pin_n,
    input  wire logic               supply_good,
    input  wire logic               low_voltage,
    input  wire logic               flash_erase_req,
    input  wire logic               flash_write_req,
    input  wire logic [FL_AW-1:0]   flash_addr,
    input  wire logic               debug_reset_req,

    // Chip side
    output logic                    chip_reset,
    output logic [15:0]             boot_address,
    output logic                    irq
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    rsc_regs_s              s;
    rsc_regs_s              next_s;

    logic [CAUSE_W-1:0]     ev;
    logic [CAUSE_W-1:0]     sel;
    logic                   pin_held;
    logic                   wr;
    logic                   wr_cause;
    logic                   wr_wctl;
    logic                   wr_ien;
    logic                   wr_iclr;
    logic                   acc;
    logic [9:0]             a_idx;
    logic [31:0]            rd_val;
    logic                   ev_pow;
    logic                   ev_ext;
    logic                   ev_lvd;
    logic                   ev_wdt;
    logic                   ev_fed;
    logic                   ev_dbg;
    logic                   ev_soft;
    logic [CAUSE_W-1:0]     above;

    // ------------------------------------------------------------
    // Bus data phase decode
    // ------------------------------------------------------------
    assign wr       = s.dp_act && s.dp_wr;
    assign wr_cause = wr && (s.dp_idx == IDX_CAUSE);
    assign wr_wctl  = wr && (s.dp_idx == IDX_WCTL);
    assign wr_ien   = wr && (s.dp_idx == IDX_IEN);
    assign wr_iclr  = wr && (s.dp_idx == IDX_ICLR);

    // ------------------------------------------------------------
    // Source events
    // ------------------------------------------------------------
    // Taken from registered state and inputs only, so the pick
    // below never loops back through the next-state logic
    assign pin_held = !s.sync2 && (s.pin_cnt == PIN_LOW_CYC);
    assign ev_ext   = !s.sync2
                    && (s.pin_cnt == PIN_LOW_CYC - 13'h0001);
    assign ev_pow   = !supply_good;
    assign ev_lvd   = low_voltage && (s.st != ST_POWER);
    // A refresh in the wrap cycle still saves the chip
    assign ev_wdt   = (s.st == ST_RUN) && s.wdt_en
                    && (s.wdt_cnt == WDT_MAX)
                    && !(wr_wctl && hwdata[WCTL_REFRESH]);
    // Flash guard has no enable at all
    assign ev_fed   = (flash_erase_req && (flash_addr >= FL_SECT_BASE))
                    || (flash_write_req
                    && (flash_addr == FL_LAST_BYTE));
    assign ev_dbg   = debug_reset_req;
    assign ev_soft  = wr_cause && hwdata[B_SOFT];
    // Reserved position never records a cause
    assign ev       = {ev_pow, ev_ext, ev_lvd, 1'b0,
                       ev_wdt, ev_fed, ev_dbg, ev_soft};

    // ------------------------------------------------------------
    // Cause pick
    // ------------------------------------------------------------
    // Highest set bit wins; power-on sits on top
    generate
        for (genvar g = 0; g < CAUSE_W; g++) begin : g_pick
            if (g == CAUSE_W - 1) begin : g_top
                assign above[g] = 1'b0;
            end else begin : g_below
                assign above[g] = |ev[CAUSE_W-1:g+1];
            end
            assign sel[g] = ev[g] && !above[g];
        end
    endgenerate

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_s = s;
        rd_val = '0;

        // Pin synchroniser; only the second stage is used
        next_s.sync1 = external_reset_pin_n;
        next_s.sync2 = s.sync1;

        // Low-time counter saturates at the threshold
        if (s.sync2) begin
            next_s.pin_cnt = '0;
        end else if (s.pin_cnt != PIN_LOW_CYC) begin
            next_s.pin_cnt = s.pin_cnt + 13'h0001;
        end

        // Watchdog: cleared and stopped while the chip is held
        if (s.st != ST_RUN) begin
            next_s.wdt_en  = 1'b0;
            next_s.wdt_cnt = '0;
        end else begin
            if (wr_wctl) begin
                next_s.wdt_en = hwdata[WCTL_EN];
            end
            if (wr_wctl && hwdata[WCTL_REFRESH]) begin
                next_s.wdt_cnt = '0;
            end else if (s.wdt_en) begin
                if (s.wdt_cnt == WDT_MAX) begin
                    next_s.wdt_cnt = '0;
                end else begin
                    next_s.wdt_cnt = s.wdt_cnt + 16'h0001;
                end
            end
        end

        // Cause record; a new cause beats a same-cycle clear
        if (wr_cause && hwdata[B_POW]) begin
            next_s.cause = s.cause & ~CAUSE_CLR_MASK;
        end
        if (|sel) begin
            next_s.cause = sel;
        end

        // Sequencer
        unique case (s.st)
            ST_POWER: begin
                if (supply_good) begin
                    next_s.st       = ST_HOLD;
                    next_s.hold_cnt = '0;
                end
            end
            ST_HOLD: begin
                // Level sources keep the chip held
                if (pin_held || low_voltage) begin
                    next_s.hold_cnt = '0;
                end else if (s.hold_cnt == HOLD_CYC) begin
                    next_s.st = ST_RUN;
                end else begin
                    next_s.hold_cnt = s.hold_cnt + 4'h1;
                end
            end
            ST_RUN: begin
            end
            default: begin
                next_s.st = ST_POWER;
            end
        endcase

        if (|sel) begin
            next_s.st       = supply_good ? ST_HOLD : ST_POWER;
            next_s.hold_cnt = '0;
        end

        next_s.chip_rst  = (next_s.st != ST_RUN);
        next_s.boot_addr = BOOT_ADDR;

        // Interrupt status: set wins over clear
        if (wr_iclr) begin
            next_s.int_sts = s.int_sts & ~hwdata[CAUSE_W-1:0];
        end
        next_s.int_sts = next_s.int_sts | sel;
        if (wr_ien) begin
            next_s.int_en = hwdata[CAUSE_W-1:0];
        end
        next_s.irq = |(next_s.int_sts & next_s.int_en);

        // Bus address phase; reads see this cycle's writes
        acc   = hsel && htrans[HTRANS_ACT_BIT] && hready;
        a_idx = haddr[IDX_MSB:IDX_LSB];
        next_s.dp_act = acc;
        if (acc) begin
            next_s.dp_wr  = hwrite;
            next_s.dp_idx = a_idx;
        end
        unique case (a_idx)
            IDX_CAUSE: rd_val = {24'h000000, next_s.cause};
            IDX_WCTL:  rd_val = {31'h00000000, next_s.wdt_en};
            IDX_ISTS:  rd_val = {24'h000000, next_s.int_sts};
            IDX_IEN:   rd_val = {24'h000000, next_s.int_en};
            default:   rd_val = '0;
        endcase
        if (acc && !hwrite) begin
            next_s.hrdata = rd_val;
        end
        next_s.rdy = 1'b1;
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            s          <= '0;
            s.st       <= ST_POWER;
            s.cause    <= CAUSE_RST;
            s.chip_rst <= 1'b1;
            s.sync1    <= 1'b1;
            s.sync2    <= 1'b1;
            s.rdy      <= 1'b1;
            s.boot_addr <= BOOT_ADDR;
        end else begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign hreadyout    = s.rdy;
    assign hrdata       = s.hrdata;
    assign hresp        = HRESP_OKAY;
    assign chip_reset   = s.chip_rst;
    assign boot_address = s.boot_addr;
    assign irq          = s.irq;

endmodule : rsc_reset_source_control

// ===== tb_reset_source_control.sv
// Purpose: Directed bench for the reset source controller
// Assumes: Zero-wait slave; short pin filter of 8 cycles
// Notes:   The watchdog run dominates run time
`timescale 1ns/1ps
module tb_reset_source_control;
    import rsc_pkg::*;
    logic ref_clk, reset, hsel, hwrite, hreadyout, hresp, irq, chip_reset;
    logic external_reset_pin_n, supply_good, low_voltage;
    logic flash_erase_req, flash_write_req, debug_reset_req;
    logic [1:0]       htrans;
    logic [31:0]      haddr, hwdata, hrdata, rd;
    logic [FL_AW-1:0] flash_addr;
    logic [15:0]      boot_address;
    int               failures = 0;
    int               num_checks = 0;
    int               cycles = 0;
    int               kd [8] = '{0, 1, 2, 2, 3, 0, 2, 3};
    logic [13:0]      fa [8] = '{14'h0, 14'h0, 14'h3F80, 14'h3FFF,
                                 14'h3FFF, 14'h0, 14'h3F7F, 14'h3FFE};
    logic [7:0]       ex [8] = '{8'h40, 8'h20, 8'h04, 8'h04, 8'h04, 8'h00, 8'h00, 8'h00};

    rsc_reset_source_control #(.PIN_LOW_CYC(13'h8)) rsc_reset_source_control_i (
        .ref_clk(ref_clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .external_reset_pin_n(external_reset_pin_n), .supply_good(supply_good),
        .low_voltage(low_voltage), .flash_erase_req(flash_erase_req),
        .flash_write_req(flash_write_req), .flash_addr(flash_addr),
        .debug_reset_req(debug_reset_req), .chip_reset(chip_reset),
        .boot_address(boot_address), .irq(irq)
    );

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles > 95000) begin
            failures++;
            final_report();
        end
    end

    task automatic final_report;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : final_report

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic bus(input logic wr, input logic [9:0] idx, input logic [31:0] wd);
        @(posedge ref_clk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr  <= {20'h0, idx, 2'h0};
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus

    task automatic rchk(input string name, input logic [9:0] idx, input logic [31:0] exp);
        bus(1'b0, idx, 32'h0);
        chk(name, rd, exp);
    endtask : rchk

    task automatic quiet;
        external_reset_pin_n <= 1'b1;
        low_voltage          <= 1'b0;
        flash_erase_req      <= 1'b0;
        flash_write_req      <= 1'b0;
        debug_reset_req      <= 1'b0;
    endtask : quiet

    // Waits for the chip reset pulse, drops all sources, then reads the cause
    task automatic seen(input logic [7:0] cause, input int lim);
        int n;
        n = 0;
        while (chip_reset !== 1'b1 && n < lim) begin
            @(posedge ref_clk);
            n++;
        end
        chk("chip_reset high", {31'h0, chip_reset}, 32'h1);
        quiet();
        n = 0;
        while (chip_reset !== 1'b0 && n < 60) begin
            @(posedge ref_clk);
            n++;
        end
        chk("chip_reset low", {31'h0, chip_reset}, 32'h0);
        rchk("cause", IDX_CAUSE, {24'h0, cause});
    endtask : seen

    initial begin
        {hsel, hwrite, htrans, haddr, hwdata, supply_good, flash_addr} <= '0;
        reset <= 1'b1;
        quiet();
        repeat (10) @(posedge ref_clk);
        reset <= 1'b0;
        repeat (20) @(posedge ref_clk);
        chk("held", {31'h0, chip_reset}, 32'h1);
        chk("boot", {16'h0, boot_address}, 32'h0);
        rchk("power cause", IDX_CAUSE, 32'h80);
        supply_good <= 1'b1;
        seen(8'h80, 2);
        bus(1'b1, IDX_CAUSE, 32'h7E);
        rchk("ro bits", IDX_CAUSE, 32'h80);
        bus(1'b1, IDX_CAUSE, 32'h80);
        rchk("cleared", IDX_CAUSE, 32'h0);
        rchk("unmapped", 10'h0D0, 32'h0);
        chk("hresp", {31'h0, hresp}, 32'h0);
        chk("hreadyout", {31'h0, hreadyout}, 32'h1);
        bus(1'b1, IDX_IEN, 32'h01);
        bus(1'b1, IDX_CAUSE, 32'h01);
        seen(8'h01, 10);
        chk("irq set", {31'h0, irq}, 32'h1);
        bus(1'b1, IDX_ICLR, 32'hFF);
        rchk("int clear", IDX_ISTS, 32'h0);
        chk("irq clear", {31'h0, irq}, 32'h0);
        bus(1'b1, IDX_IEN, 32'h0);
        debug_reset_req <= 1'b1;
        seen(8'h02, 10);
        chk("irq masked", {31'h0, irq}, 32'h0);
        rchk("int status", IDX_ISTS, 32'h02);
        bus(1'b1, IDX_CAUSE, 32'h80);
        rchk("debug kept", IDX_CAUSE, 32'h02);
        for (int i = 0; i < 8; i++) begin
            flash_addr <= fa[i];
            @(posedge ref_clk);
            case (kd[i])
                0: external_reset_pin_n <= 1'b0;
                1: low_voltage <= 1'b1;
                2: flash_erase_req <= 1'b1;
                default: flash_write_req <= 1'b1;
            endcase
            if (ex[i] != 8'h0) begin
                seen(ex[i], 40);
            end else begin
                repeat (6) @(posedge ref_clk);
                quiet();
                repeat (12) @(posedge ref_clk);
                chk("no reset", {31'h0, chip_reset}, 32'h0);
            end
        end
        bus(1'b1, IDX_WCTL, 32'h01);
        rchk("wdt ctl", IDX_WCTL, 32'h01);
        repeat (10000) @(posedge ref_clk);
        bus(1'b1, IDX_WCTL, 32'h03);
        repeat (60000) @(posedge ref_clk);
        chk("refreshed", {31'h0, chip_reset}, 32'h0);
        seen(8'h08, 6000);
        final_report();
    end
endmodule : tb_reset_source_control
